// >>> fewc_pkg.sv
// Package for the flash store erase/write command handler
package fewc_pkg;
  localparam int unsigned BLOCK_COUNT       = 119;
  localparam int unsigned BLOCK_BYTES       = 512;
  localparam int unsigned STORE_BYTES       = BLOCK_COUNT * BLOCK_BYTES;
  localparam int unsigned ADDR_W            = 16;
  localparam logic [7:0]  CMD_ERASE         = 8'h01;
  localparam logic [7:0]  CMD_WRITE         = 8'h02;
  localparam logic [7:0]  CMD_ERASE_WRITE   = 8'h03;
  localparam logic [7:0]  RESP_FLAG         = 8'h80;
  localparam logic [7:0]  ERASED_BYTE       = 8'hff;
  localparam logic [7:0]  STATUS_OK         = 8'h00;
  localparam logic [7:0]  STATUS_FAIL       = 8'h01;
  localparam logic [15:0] ZERO_COUNT        = 16'h0000;
  localparam logic [3:0]  HDR_BYTES         = 4'h8;
  localparam logic [3:0]  OFS_CMD           = 4'h0;
  localparam logic [3:0]  OFS_OPT           = 4'h1;
  localparam logic [3:0]  OFS_BLK_HI        = 4'h2;
  localparam logic [3:0]  OFS_BLK_LO        = 4'h3;
  localparam logic [3:0]  OFS_IDX_HI        = 4'h4;
  localparam logic [3:0]  OFS_IDX_LO        = 4'h5;
  localparam logic [3:0]  OFS_CNT_HI        = 4'h6;
  localparam logic [3:0]  OFS_CNT_LO        = 4'h7;

  typedef struct packed {
    logic [7:0]  command_code_byte;
    logic [7:0]  result_status_byte;
    logic [15:0] block_number_field;
    logic [15:0] byte_index_field;
    logic [15:0] byte_count_field;
    logic [7:0]  endpoint;
  } fewc_resp_s;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } fewc_byte_s;
endpackage

// >>> fewc_top.sv
// Erase / write / erase-then-write handler for the general flash store
`timescale 1ns/1ps
// Functional notes
// - Command 0x01 erases one block or all blocks so every erased bit reads 1.
// - An erase with byte count 0 erases the whole store and ignores the block number.
// - Erase works on whole blocks only; start index is sent as 0 and not used.
// - A unicast erase is answered with code 0x81 to the request's source endpoint.
// - Status bit 0 is 1 on failure and 0 on success; other status bits are zero.
// - The erase answer echoes block number and start index unchanged.
// - The erase answer reports byte count 0 and carries no data.
// - Command 0x03 erases the whole addressed block, then writes the data.
// - Payload: command, options, block, index, count, then data from offset 8, big-endian.
// - A broadcast request is carried out but gets no answer.
// - The store is 119 blocks of 512 bytes each.
module fewc_top (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rstn,
  // Request byte stream
  input  wire fewc_pkg::fewc_byte_s i_req,
  input  wire logic                i_broadcast,
  input  wire logic [7:0]          i_src_endpoint,
  output logic                     o_req_ready,
  // Flash read port for store inspection
  input  wire logic [15:0]         i_rd_addr,
  output logic [7:0]               o_rd_data,
  // Response
  output fewc_pkg::fewc_resp_s     o_resp,
  output logic                     o_resp_valid,
  output logic                     o_busy
);
  import fewc_pkg::*;

  typedef enum logic [3:0] {
    ST_RECV  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_RESP  = 4'b1000
  } fewc_state_e;

  logic [7:0]  mem [STORE_BYTES];
  logic [7:0]  buf_data [BLOCK_BYTES];

  fewc_state_e state;
  logic [3:0]  hdr_pos;
  logic [7:0]  cmd;
  logic [15:0] blk;
  logic [15:0] idx;
  logic [15:0] cnt;
  logic [15:0] dcnt;
  logic [15:0] ptr;
  logic [15:0] end_ptr;
  logic        bcast;
  logic [7:0]  src_ep;
  logic        fmt_err;
  logic        end_req_q;

  // Header field decode
  wire         in_hdr     = (hdr_pos < HDR_BYTES);
  wire         req_take   = i_req.valid && (state == ST_RECV);
  wire         first_b    = req_take && i_req.first;
  wire [3:0]   cur_pos    = i_req.first ? OFS_CMD : hdr_pos;
  wire         hdr_b      = req_take && (i_req.first || in_hdr);
  wire         data_b     = req_take && !i_req.first && !in_hdr;
  wire         end_req    = req_take && i_req.last;
  wire [16:0]  span       = {1'b0, idx} + {1'b0, cnt};
  wire         known_cmd  = (cmd == CMD_ERASE) || (cmd == CMD_WRITE) || (cmd == CMD_ERASE_WRITE);
  wire         is_erase   = (cmd == CMD_ERASE);
  wire         erase_all  = is_erase && (cnt == ZERO_COUNT);
  wire         blk_bad    = !erase_all && (blk >= 16'(BLOCK_COUNT));
  wire         span_bad   = !is_erase && (span > 17'(BLOCK_BYTES));
  wire         len_bad    = !is_erase && (dcnt != cnt);
  wire         fail       = !known_cmd || blk_bad || span_bad || len_bad || fmt_err;
  wire [15:0]  blk_base   = 16'(blk * 16'(BLOCK_BYTES));
  wire [15:0]  er_start   = erase_all ? 16'h0000 : blk_base;
  wire [15:0]  er_end     = erase_all ? 16'(STORE_BYTES - 1) : 16'(blk_base + 16'(BLOCK_BYTES - 1));
  wire [15:0]  wr_start   = 16'(blk_base + idx);
  wire [15:0]  wr_end     = 16'(wr_start + cnt - 16'h0001);
  wire [15:0]  buf_idx    = 16'(ptr - wr_start);
  wire         wr_empty   = (cnt == ZERO_COUNT);
  wire         at_end     = (ptr == end_ptr);

  // Request payload, big-endian fields
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hdr_pos <= 4'h0;
      cmd     <= 8'h00;
      blk     <= 16'h0000;
      idx     <= 16'h0000;
      cnt     <= 16'h0000;
      dcnt    <= 16'h0000;
      bcast   <= 1'b0;
      src_ep  <= 8'h00;
      fmt_err <= 1'b0;
    end else if (hdr_b) begin
      unique case (cur_pos)
        OFS_CMD:    cmd <= i_req.data;
        OFS_BLK_HI: blk[15:8] <= i_req.data;
        OFS_BLK_LO: blk[7:0] <= i_req.data;
        OFS_IDX_HI: idx[15:8] <= i_req.data;
        OFS_IDX_LO: idx[7:0] <= i_req.data;
        OFS_CNT_HI: cnt[15:8] <= i_req.data;
        OFS_CNT_LO: cnt[7:0] <= i_req.data;
        default: ;
      endcase
      hdr_pos <= 4'(cur_pos + 4'h1);
      if (first_b) begin
        dcnt    <= 16'h0000;
        bcast   <= i_broadcast;
        src_ep  <= i_src_endpoint;
        fmt_err <= 1'b0;
      end
      if (i_req.last && (cur_pos != OFS_CNT_LO)) begin
        fmt_err <= 1'b1;
      end
    end else if (data_b) begin
      dcnt <= 16'(dcnt + 16'h0001);
    end
  end

  // Data bytes held until the block is ready
  always_ff @(posedge i_clk) begin
    if (data_b && (dcnt < 16'(BLOCK_BYTES))) begin
      buf_data[dcnt[8:0]] <= i_req.data;
    end
  end

  // Sequencer
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state        <= ST_RECV;
      ptr          <= 16'h0000;
      end_ptr      <= 16'h0000;
      o_resp       <= '0;
      o_resp_valid <= 1'b0;
      o_busy       <= 1'b0;
      o_req_ready  <= 1'b0;
    end else begin
      o_resp_valid <= 1'b0;
      unique case (state)
        ST_RECV: begin
          o_req_ready <= 1'b1;
          o_busy      <= 1'b0;
          if (state == ST_RECV && end_req_q) begin
            o_req_ready <= 1'b0;
            o_busy      <= 1'b1;
            if (fail) begin
              state <= ST_RESP;
            end else if (cmd == CMD_WRITE) begin
              state   <= wr_empty ? ST_RESP : ST_WRITE;
              ptr     <= wr_start;
              end_ptr <= wr_end;
            end else begin
              state   <= ST_ERASE;
              ptr     <= er_start;
              end_ptr <= er_end;
            end
          end
        end
        ST_ERASE: begin
          if (at_end) begin
            ptr     <= wr_start;
            end_ptr <= wr_end;
            state   <= (is_erase || wr_empty) ? ST_RESP : ST_WRITE;
          end else begin
            ptr <= 16'(ptr + 16'h0001);
          end
        end
        ST_WRITE: begin
          if (at_end) begin
            state <= ST_RESP;
          end else begin
            ptr <= 16'(ptr + 16'h0001);
          end
        end
        ST_RESP: begin
          state       <= ST_RECV;
          o_busy      <= 1'b0;
          o_req_ready <= 1'b1;
          o_resp_valid <= !bcast;
          o_resp.command_code_byte  <= cmd | RESP_FLAG;
          o_resp.endpoint           <= src_ep;
          o_resp.result_status_byte <= fail ? STATUS_FAIL : STATUS_OK;
          o_resp.block_number_field <= blk;
          o_resp.byte_index_field   <= idx;
          o_resp.byte_count_field   <= ZERO_COUNT;
        end
      endcase
    end
  end

  // Request end seen one cycle later, once its byte is stored
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      end_req_q <= 1'b0;
    end else begin
      end_req_q <= end_req;
    end
  end

  // Flash array: erase writes ones, write stores data
  always_ff @(posedge i_clk) begin
    if (state == ST_ERASE) begin
      mem[ptr] <= ERASED_BYTE;
    end else if (state == ST_WRITE) begin
      mem[ptr] <= buf_data[buf_idx[8:0]];
    end
  end

  always_ff @(posedge i_clk) begin
    o_rd_data <= (i_rd_addr < 16'(STORE_BYTES)) ? mem[i_rd_addr] : ERASED_BYTE;
  end
endmodule

// >>> fewc_top_sva.sv
// Assertion checker for the flash store command handler
`timescale 1ns/1ps
module fewc_top_sva (
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_rstn,
  // Request, read port and answer
  input wire fewc_pkg::fewc_byte_s i_req,
  input wire logic                 i_broadcast,
  input wire logic [7:0]           i_src_endpoint,
  input wire logic                 o_req_ready,
  input wire logic [15:0]          i_rd_addr,
  input wire logic [7:0]           o_rd_data,
  input wire fewc_pkg::fewc_resp_s o_resp,
  input wire logic                 o_resp_valid,
  input wire logic                 o_busy
);
  import fewc_pkg::*;
  logic [7:0]  cmd_q;
  logic [7:0]  ep_q;
  logic        bc_q;
  logic [3:0]  ofs;
  logic [31:0] bi_q;
  wire         take = i_req.valid && o_req_ready;
  // Header capture of the request in flight
  always_ff @(posedge i_clk) begin
    if (take) begin
      ofs <= i_req.first ? 4'h1 : ofs + {3'h0, ofs != 4'hf};
    end
    if (take && i_req.first) begin
      cmd_q <= i_req.data;
      ep_q <= i_src_endpoint;
      bc_q <= i_broadcast;
    end
    if (take && !i_req.first && ofs inside {[4'h2:4'h5]}) begin
      bi_q <= {bi_q[23:0], i_req.data};
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  resp_code_a: assert property (o_resp_valid |-> o_resp.command_code_byte == (cmd_q | RESP_FLAG))
    else $error("answer code wrong");
  resp_dest_a: assert property (o_resp_valid |-> o_resp.endpoint == ep_q)
    else $error("answer endpoint wrong");
  bcast_quiet_a: assert property (o_resp_valid |-> !bc_q)
    else $error("broadcast answered");
  status_bits_a: assert property (o_resp_valid |-> o_resp.result_status_byte[7:1] == 7'h00)
    else $error("status high bits set");
  zero_count_a: assert property (o_resp_valid |-> o_resp.byte_count_field == ZERO_COUNT)
    else $error("answer count not zero");
  echo_fields_a: assert property (o_resp_valid |-> {o_resp.block_number_field, o_resp.byte_index_field} == bi_q)
    else $error("block or index not echoed");
  busy_end_a: assert property (o_resp_valid |-> $fell(o_busy))
    else $error("busy not ending with answer");
  oob_read_a: assert property (i_rd_addr >= 16'hee00 |=> o_rd_data == ERASED_BYTE)
    else $error("read past store not erased value");
endmodule
bind fewc_top fewc_top_sva i_fewc_top_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_broadcast(i_broadcast),
  .i_src_endpoint(i_src_endpoint), .o_req_ready(o_req_ready), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
  .o_resp(o_resp), .o_resp_valid(o_resp_valid), .o_busy(o_busy));

// >>> fewc_requester.sv
// Requesting node model feeding command payloads byte by byte
`timescale 1ns/1ps
module fewc_requester (
  // Clock and flow control
  input  wire logic            i_clk,
  input  wire logic            i_ready,
  // Payload stream
  output fewc_pkg::fewc_byte_s o_req
);
  import fewc_pkg::*;
  initial o_req = '0;
  // count and size chosen by caller
  task automatic send(input logic [7:0] cmd, input logic [15:0] blk, idx, cnt, input int nd);
    logic [7:0] b[$];
    b = {cmd, 8'h00, blk[15:8], blk[7:0], idx[15:8], idx[7:0], cnt[15:8], cnt[7:0]};
    for (int k = 0; k < nd; k++) b.push_back(8'ha0 + 8'(k));
    foreach (b[k]) begin
      @(negedge i_clk);
      while (!i_ready) @(negedge i_clk);
      o_req = '{1'b1, k == 0, k == b.size() - 1, b[k]};
    end
    @(negedge i_clk);
    o_req = '{1'b0, 1'b0, 1'b0, ~o_req.data};
  endtask
endmodule

// >>> fewc_top_bench.sv
// Self-checking bench for the flash store command handler
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module fewc_top_bench;
  import fewc_pkg::*;
  typedef struct packed {logic [7:0] cmd; logic [15:0] blk, idx, cnt; logic [7:0] nd, st;} fewc_row_s;
  logic        i_clk = 0, i_rstn = 0, i_broadcast = 0, o_req_ready, o_resp_valid, o_busy, seen;
  logic [7:0]  i_src_endpoint = '0, o_rd_data;
  logic [15:0] i_rd_addr = '0;
  fewc_byte_s  i_req;
  fewc_resp_s  o_resp;
  int          err_count = 0, tests_run = 0;
  fewc_row_s   rows [9] = '{'{8'h01, 16'h0005, 16'h0000, 16'h0000, 8'h00, 8'h00},
    '{8'h02, 16'h0003, 16'h0020, 16'h0001, 8'h01, 8'h00}, '{8'h03, 16'h0003, 16'h0010, 16'h0001, 8'h01, 8'h00},
    '{8'h02, 16'h0076, 16'h01fe, 16'h0002, 8'h02, 8'h00}, '{8'h01, 16'h0076, 16'h0000, 16'h0200, 8'h00, 8'h00},
    '{8'h02, 16'h0077, 16'h0000, 16'h0001, 8'h01, 8'h01}, '{8'h02, 16'h0001, 16'h01ff, 16'h0002, 8'h02, 8'h01},
    '{8'h02, 16'h0003, 16'h0011, 16'h0001, 8'h02, 8'h01}, '{8'h07, 16'h0001, 16'h0000, 16'h0000, 8'h00, 8'h01}};
  fewc_requester i_fewc_requester (.i_clk(i_clk), .i_ready(o_req_ready), .o_req(i_req));
  fewc_top i_fewc_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_broadcast(i_broadcast),
    .i_src_endpoint(i_src_endpoint), .o_req_ready(o_req_ready), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
    .o_resp(o_resp), .o_resp_valid(o_resp_valid), .o_busy(o_busy));
  initial forever #50 i_clk = ~i_clk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_resp(input int lim);
    seen = 0;
    repeat (lim) begin
      @(negedge i_clk);
      if (o_resp_valid === 1'b1) begin
        seen = 1;
        break;
      end
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_rd_addr = a;
    @(negedge i_clk);
    `CHK("flash byte", e, o_rd_data)
  endtask
  // Watchdog well past the erase-all run
  initial begin
    #9000000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge i_clk);
    i_rstn = 1;
    foreach (rows[r]) begin
      i_src_endpoint = 8'h10 + 8'(r);
      i_fewc_requester.send(rows[r].cmd, rows[r].blk, rows[r].idx, rows[r].cnt, rows[r].nd);
      wait_resp(70000);
      `CHK("answer seen", 1'b1, seen)
      `CHK("answer", {rows[r].cmd | RESP_FLAG, rows[r].st, rows[r].blk, rows[r].idx, ZERO_COUNT, i_src_endpoint}, o_resp)
      $display("row %0d done", r);
    end
    rd(16'h0610, 8'ha0);
    rd(16'h0620, ERASED_BYTE);
    rd(16'hedfe, ERASED_BYTE);
    rd(16'h03ff, ERASED_BYTE);
    rd(16'h6400, ERASED_BYTE);
    rd(16'hffff, ERASED_BYTE);
    $display("reads done");
    i_broadcast = 1;
    i_fewc_requester.send(CMD_WRITE, 16'h0009, 16'h0000, 16'h0001, 1);
    wait_resp(40);
    `CHK("broadcast answer", 1'b0, seen)
    rd(16'h1200, 8'ha0);
    $display("broadcast done");
    i_rstn = 0;
    #1;
    `CHK("reset outputs", 3'b000, {o_req_ready, o_busy, o_resp_valid})
    `CHK("reset answer", 72'h0, o_resp)
    $display("reset done");
    finish_test();
  end
endmodule
